// *** hdl/clk_div_defs.svh ***
// Offsets, field positions, reset values and timing figures of the clock divider block.
`ifndef CLK_DIV_DEFS_SVH
`define CLK_DIV_DEFS_SVH

`define SRC_SEL_INDEX     16'h1c82
`define DIV3_INDEX        16'h1c90
`define OSC_DIV_INDEX     16'h1c92
`define WAKE_INDEX        16'h1c98
`define REG_ADDR(idx)     ((idx) << 2)

`define DIV_ON_BIT        15
`define DIV_RATIO_MSB     4
`define WAKE_MSB          4
`define SEL_MSB           3

`define DIV3_ON_RESET     1'b1
`define DIV3_RATIO_RESET  5'h03
`define OSC_ON_RESET      1'b0
`define OSC_RATIO_RESET   5'h00
`define WAKE_RESET        5'h1f
`define SEL_RESET         4'hb

`define SEL_TAP_A         4'h9
`define SEL_TAP_B         4'ha
`define SEL_TAP_C         4'hb

`define REF_CLK_HZ        25000000
`define REF_CLK_PERIOD_NS 40

`endif

// *** hdl/clk_div_pkg.sv ***
// Types shared by the clock divider and wake-up control block.
package clk_div_pkg;

  typedef struct packed {
    logic       on;
    logic [4:0] ratio;
  } divider_cfg_s;

  typedef struct packed {
    logic irq3;
    logic irq2;
    logic irq1;
    logic irq0;
    logic nmi;
  } wake_pins_s;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

  typedef enum logic [1:0] {
    SRC_OSC_DIV,
    SRC_TAP,
    SRC_NONE
  } source_kind_e;

endpackage

// *** hdl/tick_divider.sv ***
// Enable-pulse divider with clean restart and ratio changes taken at period boundaries.
`timescale 1ns/1ps
module tick_divider (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      src_tick,
  input  wire clk_div_pkg::divider_cfg_s cfg,
  input  wire logic [4:0]                count_last,
  output logic                           out_tick
);

  logic [4:0] count;
  logic [4:0] active_last;
  logic       wrap;
  logic [4:0] next_count;

  assign wrap       = src_tick && (count == active_last);
  assign next_count = wrap ? 5'h00 : 5'(count + 5'h01);

  // A disabled divider stays low and restarts from count zero.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !cfg.on)
    begin
      count       <= 5'h00;
      active_last <= count_last;
      out_tick    <= 1'b0;
    end
    else
    begin
      out_tick <= wrap;
      if (src_tick)
      begin
        count <= next_count;
      end
      if (wrap)
      begin
        active_last <= count_last;
      end
    end
  end

endmodule

// *** hdl/clock_divider_wakeup_ctl.sv ***
// Third system-clock divider, oscillator divider, wake-up enables and third output selector.
`timescale 1ns/1ps
`include "clk_div_defs.svh"

// Behaviour
// - Bit 15 of the third divider register switches that divider off at 0 and on at 1, reset 1.
// - The third divider ratio divides by 1, 2 or 4 for codes 0, 1 and 3, resetting to 3.
// - The third divider sits in both the bypass and the PLL path.
// - Bit 15 of the oscillator divider register switches it on, and it resets off.
// - The oscillator divider divides by its ratio field plus one, resetting to divide by 1.
// - The oscillator divider counts the reference clock directly, never the PLL.
// - While the oscillator is powered down, a rising edge on an enabled input wakes it.
// - Wake bits 4 to 0 belong to interrupts 3, 2, 1, 0 and the non-maskable interrupt.
// - An input whose wake bit is 1 cannot wake the oscillator.
// - All five wake bits reset to 1.
// - Select codes 0 to 7 drive the third output from the oscillator divider.
// - Select codes 9, 10 and 11 drive the third output from taps A, B and C, reset 11.
// - Reserved register bits read zero and writes to them change nothing.
module clock_divider_wakeup_ctl (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [15:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    pll_mode,
  input  wire logic                    pll_tick,
  input  wire logic                    tap_a_tick,
  input  wire logic                    tap_b_tick,
  input  wire logic                    tap_c_tick,
  input  wire clk_div_pkg::wake_pins_s wake_pins,
  input  wire logic                    oscillator_powered_down,
  output logic                         osc_wake,
  output logic                         system_clock_three,
  output logic                         third_clock_output
);

  // Turns a third divider code into the last count of its period.
  function automatic logic [4:0] div3_last(input logic [4:0] code);
    logic [4:0] last;
    last = 5'h00;
    case (code)
      5'h00:   last = 5'h00;
      5'h01:   last = 5'h01;
      5'h03:   last = 5'h03;
      default: last = code;
    endcase
    return last;
  endfunction

  // Classifies a select code.
  function automatic clk_div_pkg::source_kind_e sel_kind(input logic [3:0] code);
    clk_div_pkg::source_kind_e kind;
    kind = clk_div_pkg::SRC_NONE;
    if (!code[3])
    begin
      kind = clk_div_pkg::SRC_OSC_DIV;
    end
    else if (code == `SEL_TAP_A || code == `SEL_TAP_B || code == `SEL_TAP_C)
    begin
      kind = clk_div_pkg::SRC_TAP;
    end
    return kind;
  endfunction

  // Places a divider's enable and ratio at their register bit positions.
  function automatic logic [31:0] div_word(input clk_div_pkg::divider_cfg_s cfg);
    logic [31:0] word;
    word                   = 32'h00000000;
    word[`DIV_ON_BIT]      = cfg.on;
    word[`DIV_RATIO_MSB:0] = cfg.ratio;
    return word;
  endfunction

  // Takes a divider's enable and ratio from a write word; every other bit is dropped.
  function automatic clk_div_pkg::divider_cfg_s div_fields(input logic [31:0] word);
    clk_div_pkg::divider_cfg_s cfg;
    cfg.on    = word[`DIV_ON_BIT];
    cfg.ratio = word[`DIV_RATIO_MSB:0];
    return cfg;
  endfunction

  // Matches a bus address against the byte address of a register index.
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] index);
    return addr == 16'(`REG_ADDR(index));
  endfunction

  clk_div_pkg::divider_cfg_s div3_cfg;
  clk_div_pkg::divider_cfg_s osc_cfg;
  logic [`WAKE_MSB:0]        wake_block;
  logic [`SEL_MSB:0]         sel_reg;
  logic [`SEL_MSB:0]         sel_active;

  clk_div_pkg::apb_req_s     req;
  logic                      setup;
  logic                      access;
  logic                      hit_sel;
  logic                      hit_div3;
  logic                      hit_osc;
  logic                      hit_wake;
  logic                      mapped;
  logic                      wr_en;
  logic                      wr_div3;
  logic                      wr_osc;
  logic                      wr_wake;
  logic                      wr_sel;
  logic [31:0]               next_rdata;

  assign req.write = pwrite;
  assign req.addr  = paddr;
  assign req.wdata = pwdata;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_sel  = reg_hit(req.addr, `SRC_SEL_INDEX);
  assign hit_div3 = reg_hit(req.addr, `DIV3_INDEX);
  assign hit_osc  = reg_hit(req.addr, `OSC_DIV_INDEX);
  assign hit_wake = reg_hit(req.addr, `WAKE_INDEX);
  assign mapped   = hit_sel || hit_div3 || hit_osc || hit_wake;
  assign wr_en    = access && req.write && mapped;
  assign wr_div3  = wr_en && hit_div3;
  assign wr_osc   = wr_en && hit_osc;
  assign wr_wake  = wr_en && hit_wake;
  assign wr_sel   = wr_en && hit_sel;

  // Only the documented fields are stored or returned; everything else reads zero.
  assign next_rdata =
      hit_sel  ? {28'h0000000, sel_reg} :
      hit_div3 ? div_word(div3_cfg) :
      hit_osc  ? div_word(osc_cfg) :
      hit_wake ? {27'h0000000, wake_block} :
                 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // Read data is captured in the setup cycle so that it comes from a flip-flop.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup)
    begin
      prdata <= req.write ? 32'h00000000 : next_rdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div3_cfg.on    <= `DIV3_ON_RESET;
      div3_cfg.ratio <= `DIV3_RATIO_RESET;
    end
    else if (wr_div3)
    begin
      div3_cfg <= div_fields(req.wdata);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_cfg.on    <= `OSC_ON_RESET;
      osc_cfg.ratio <= `OSC_RATIO_RESET;
    end
    else if (wr_osc)
    begin
      osc_cfg <= div_fields(req.wdata);
    end
  end

  // Wake bits are active low: a 0 lets that pin restart the oscillator.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wake_block <= `WAKE_RESET;
    end
    else if (wr_wake)
    begin
      wake_block <= req.wdata[`WAKE_MSB:0];
    end
  end

  // The written code waits in sel_reg until the output may switch over.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sel_reg <= `SEL_RESET;
    end
    else if (wr_sel)
    begin
      sel_reg <= req.wdata[`SEL_MSB:0];
    end
  end

  logic div3_src;
  logic osc_tick;

  assign div3_src = pll_mode ? pll_tick : 1'b1;

  tick_divider u_div3 (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .src_tick   (div3_src),
    .cfg        (div3_cfg),
    .count_last (div3_last(div3_cfg.ratio)),
    .out_tick   (system_clock_three)
  );

  tick_divider u_osc_div (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .src_tick   (1'b1),
    .cfg        (osc_cfg),
    .count_last (osc_cfg.ratio),
    .out_tick   (osc_tick)
  );

  // Wake pins come from outside and pass two flip-flops before the edge detector.
  logic [`WAKE_MSB:0] pin_meta;
  logic [`WAKE_MSB:0] pin_sync;
  logic [`WAKE_MSB:0] pin_prev;
  logic [`WAKE_MSB:0] pin_rise;
  logic               wake_hit;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_prev <= 5'h00;
    end
    else
    begin
      pin_meta <= wake_pins;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_prev;
  assign wake_hit = |(pin_rise & ~wake_block);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_wake <= 1'b0;
    end
    else
    begin
      osc_wake <= oscillator_powered_down && wake_hit;
    end
  end

  clk_div_pkg::source_kind_e active_kind;
  logic                      cur_tick;
  logic                      cur_idle;
  logic                      sel_apply;

  assign active_kind = sel_kind(sel_active);
  assign cur_tick =
      (active_kind == clk_div_pkg::SRC_OSC_DIV) ? osc_tick :
      (sel_active == `SEL_TAP_A)                ? tap_a_tick :
      (sel_active == `SEL_TAP_B)                ? tap_b_tick :
      (sel_active == `SEL_TAP_C)                ? tap_c_tick :
                                                  1'b0;
  assign cur_idle  = (active_kind == clk_div_pkg::SRC_NONE) ||
                     ((active_kind == clk_div_pkg::SRC_OSC_DIV) && !osc_cfg.on);
  assign sel_apply = cur_tick || cur_idle;

  // Unsupported codes leave the output low rather than picking a source.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sel_active         <= `SEL_RESET;
      third_clock_output <= 1'b0;
    end
    else
    begin
      third_clock_output <= cur_tick;
      if (sel_apply)
      begin
        sel_active <= sel_reg;
      end
    end
  end

endmodule

// *** dv/clk_div_asserts.sv ***
// Checker of bus read data, bus errors and pulse relations of the clock divider block.
`timescale 1ns/1ps
`include "clk_div_defs.svh"
module clk_div_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        pll_mode,
  input wire logic        pll_tick,
  input wire logic        oscillator_powered_down,
  input wire logic        osc_wake,
  input wire logic        system_clock_three
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic rd;
  logic hit_sel;
  logic hit_div;
  logic hit_wk;
  assign rd      = psel && penable && !pwrite;
  assign hit_sel = paddr == `REG_ADDR(`SRC_SEL_INDEX);
  assign hit_div = paddr == `REG_ADDR(`DIV3_INDEX) || paddr == `REG_ADDR(`OSC_DIV_INDEX);
  assign hit_wk  = paddr == `REG_ADDR(`WAKE_INDEX);
  property p_hi_zero; rd |-> prdata[31:16] == 16'h0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_sel_rsvd; rd && hit_sel |-> prdata[15:4] == 12'h000; endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("select spare bits set");
  property p_div_rsvd; rd && hit_div |-> prdata[14:5] == 10'h000; endproperty
  a_div_rsvd: assert property (p_div_rsvd) else $error("divider spare bits set");
  property p_wake_rsvd; rd && hit_wk |-> prdata[15:5] == 11'h000; endproperty
  a_wake_rsvd: assert property (p_wake_rsvd) else $error("wake spare bits set");
  property p_unmapped;
    psel && penable && !(hit_sel || hit_div || hit_wk) |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");
  property p_pll_src; pll_mode && $past(pll_mode) && system_clock_three |-> $past(pll_tick); endproperty
  a_pll_src: assert property (p_pll_src) else $error("divider pulse without source");
  property p_wake_quiet; (!oscillator_powered_down)[*4] |=> !osc_wake; endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake while running");
  property p_wake_pulse; osc_wake |=> !osc_wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
endmodule
bind clock_divider_wakeup_ctl clk_div_asserts u_chk (.ref_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .pll_mode, .pll_tick, .oscillator_powered_down, .osc_wake,
  .system_clock_three);

// *** dv/clock_divider_wakeup_ctl_tb.sv ***
// Self-checking bench of the clock divider and wake-up control block.
`timescale 1ns/1ps
`include "clk_div_defs.svh"
module clock_divider_wakeup_ctl_tb;
  logic                    ref_clk, rst, psel, penable, pwrite, pready, pslverr, last_err;
  logic [15:0]             paddr;
  logic [31:0]             pwdata, prdata;
  logic                    pll_mode, pll_tick, tap_a_tick, tap_b_tick, tap_c_tick;
  logic                    oscillator_powered_down, osc_wake, system_clock_three;
  logic                    third_clock_output;
  clk_div_pkg::wake_pins_s wake_pins;
  int                      fails, n_compared, cyc;
  int                      div_tab[12] = '{1, 2, 3, 4, 5, 6, 7, 8, 32, 2, 3, 5};
  localparam logic [15:0] addr_sel = `REG_ADDR(`SRC_SEL_INDEX);
  localparam logic [15:0] addr_d3  = `REG_ADDR(`DIV3_INDEX);
  localparam logic [15:0] addr_osc = `REG_ADDR(`OSC_DIV_INDEX);
  localparam logic [15:0] addr_wk  = `REG_ADDR(`WAKE_INDEX);
  clock_divider_wakeup_ctl uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pll_mode, .pll_tick, .tap_a_tick, .tap_b_tick, .tap_c_tick,
    .wake_pins, .oscillator_powered_down, .osc_wake, .system_clock_three, .third_clock_output);
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Source ticks at fixed distinct rates so each selected tap gives its own pulse count.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    pll_tick <= pll_mode && !pll_tick;
    tap_a_tick <= (cyc % 2) == 0;
    tap_b_tick <= (cyc % 3) == 0;
    tap_c_tick <= (cyc % 5) == 0;
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
    begin
      fails++;
      close_out;
    end
    else
      @(posedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask
  task automatic count(input int cycles, output int n3, output int nt, output int nw);
    n3 = 0;
    nt = 0;
    nw = 0;
    repeat (cycles)
    begin
      @(negedge ref_clk);
      n3 += int'(system_clock_three === 1'b1);
      nt += int'(third_clock_output === 1'b1);
      nw += int'(osc_wake === 1'b1);
    end
    @(posedge ref_clk);
  endtask
  task automatic wake_try(input int pin, input logic pd, input int exp);
    int n3, nt, w1, w2;
    oscillator_powered_down <= pd;
    wake_pins[pin] <= 1'b1;
    count(8, n3, nt, w1);
    wake_pins <= '0;
    count(8, n3, nt, w2);
    check("wake pulses", w1 + w2, exp);
  endtask
  initial
  begin
    int n3, nt, nw, r;
    {psel, penable, pwrite, pll_mode} = '0;
    paddr = '0;
    pwdata = '0;
    wake_pins = '0;
    oscillator_powered_down = 0;
    rst = 1;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    rd(addr_sel, 32'hb, "select reset");
    rd(addr_d3, 32'h8003, "div3 reset");
    rd(addr_osc, 32'h0, "osc div reset");
    rd(addr_wk, 32'h1f, "wake reset");
    for (int p = 0; p < 5; p++) wake_try(p, 1'b1, 0);
    for (int p = 0; p < 5; p++)
    begin
      wr(addr_wk, 32'h1f ^ (32'h1 << p));
      wake_try(p, 1'b1, 1);
      wake_try((p + 1) % 5, 1'b1, 0);
      wake_try(p, 1'b0, 0);
    end
    wr(addr_sel, 32'hfffffffb);
    wr(addr_d3, '1);
    wr(addr_osc, '1);
    wr(addr_wk, '1);
    rd(addr_sel, 32'hb, "select spare");
    rd(addr_d3, 32'h801f, "div3 spare");
    rd(addr_osc, 32'h801f, "osc div spare");
    rd(addr_wk, 32'h1f, "wake spare");
    rd(16'h0100, 32'h0, "unmapped read");
    check("unmapped error", last_err, 1'b1);
    for (int c = 0; c < 4; c++)
    begin
      if (c == 2) continue;
      wr(addr_d3, 32'h8000 | c);
      count(40, n3, nt, nw);
      count(48, n3, nt, nw);
      check("div3 bypass", n3, 48 / (c + 1));
    end
    wr(addr_d3, 32'h0003);
    count(40, n3, nt, nw);
    count(48, n3, nt, nw);
    check("div3 off", n3, 0);
    pll_mode <= 1;
    wr(addr_d3, 32'h8001);
    count(40, n3, nt, nw);
    count(48, n3, nt, nw);
    check("div3 pll", n3, 12);
    for (int i = 0; i < 12; i++)
    begin
      r = (i == 8) ? 31 : ((i < 8) ? i : 0);
      wr(addr_osc, 32'h8000 | r);
      wr(addr_sel, (i == 8) ? 0 : i);
      count(80, n3, nt, nw);
      count(3360, n3, nt, nw);
      check("third output", nt, 3360 / div_tab[i]);
    end
    wr(addr_sel, 32'h0);
    wr(addr_osc, 32'h001f);
    count(80, n3, nt, nw);
    count(64, n3, nt, nw);
    check("osc div off", nt, 0);
    close_out;
  end
endmodule
